// ### rtl/panel_pkg.sv
/*
  Constants shared by the front-panel console logic: select codes, fill
  fields, bootstrap range, button indices, control states and timing.
  Assumes a 100 MHz ref_clk and a 16-bit CPU word.
*/
package panel_pkg;

  localparam int WORD_W = 16;
  localparam int SEL_W = 6;

  // ----------------------------------------------------------------
  // register select codes
  // ----------------------------------------------------------------
  localparam logic [5:0] SEL_IP = 6'h3C;
  localparam logic [5:0] READ_LATCH_SELECT_CODE = 6'h3F;
  localparam logic [5:0] SRC_NONE_LO = 6'h10;
  localparam logic [5:0] SRC_NONE_HI = 6'h18;
  localparam logic [5:0] SRC_NONE_A = 6'h39;
  localparam logic [5:0] SRC_NONE_B = 6'h3B;
  localparam logic [5:0] SRC_NONE_C = 6'h3E;
  localparam logic [5:0] DEST_NONE = 6'h00;
  localparam logic [5:0] DEST_UNA_A = 6'h12;
  localparam logic [5:0] DEST_UNA_B = 6'h13;
  localparam logic [5:0] DEST_UNA_C = 6'h1A;
  localparam logic [5:0] DEST_UNA_D = 6'h1B;
  localparam logic [5:0] DEST_UNA_E = 6'h3B;
  localparam logic [5:0] DEST_PAUSE_A = 6'h14;
  localparam logic [5:0] DEST_PAUSE_B = 6'h15;
  localparam logic [5:0] DEST_PAUSE_BUS = 6'h16;
  localparam logic [5:0] DEST_PAUSE_B2 = 6'h17;
  localparam logic [5:0] DEST_IP = 6'h3C;
  localparam logic [5:0] DEST_LATCH_LO = 6'h3D;
  localparam logic [5:0] DEST_LATCH_HI = 6'h3E;
  localparam logic [5:0] DEST_LATCH = 6'h3F;

  // pause counter source encoding
  localparam logic [1:0] PSRC_A = 2'h0;
  localparam logic [1:0] PSRC_B = 2'h1;
  localparam logic [1:0] PSRC_BUS = 2'h2;

  // ----------------------------------------------------------------
  // fill
  // ----------------------------------------------------------------
  localparam int FILL_DEV_LSB = 12;
  localparam int FILL_ARG_LSB = 1;
  localparam int FILL_ARG_W = 7;
  localparam logic [5:0] FILL_LAST = 6'h2D;
  localparam logic [3:0] DEV_MOVING_DISC = 4'h1;
  localparam logic [3:0] DEV_FIXED_DISC = 4'h2;
  localparam logic [3:0] DEV_TAPE = 4'h4;
  localparam logic [3:0] DEV_CARD = 4'h5;
  localparam logic [3:0] DEV_PAPER = 4'hA;

  // ----------------------------------------------------------------
  // buttons and timing
  // ----------------------------------------------------------------
  localparam int BTN_N = 8;
  localparam int BTN_MEM_ENTER = 0;
  localparam int BTN_STEP = 1;
  localparam int BTN_DISPLAY = 2;
  localparam int BTN_REG_ENTER = 3;
  localparam int BTN_CONSOLE_INT = 4;
  localparam int BTN_SINGLE = 5;
  localparam int BTN_FILL = 6;
  localparam int BTN_MASTER_CLEAR = 7;

  localparam int CLK_PERIOD_NS = 10;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYCLES =
    (DEBOUNCE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    OP_IDLE, OP_WR_WAIT, OP_RD_WAIT, OP_CPU_WAIT, OP_ROM, OP_FILL_WR
  } op_e;

endpackage

// ### rtl/panel_debounce.sv
/*
  One pushbutton debouncer: a press must stand for CYCLES clocks before
  it counts, and then gives a single one-cycle pulse.
  Assumes raw is already synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module panel_debounce #(
  parameter int unsigned CYCLES = 500000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // button
  input wire logic raw,
  output logic press
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic stable;
    logic press;
  } db_s;

  db_s st;
  db_s next_st;

  always_comb begin
    next_st = st;
    next_st.press = 1'b0;
    if (raw == st.stable) begin
      next_st.cnt = '0;
    end else if (st.cnt == LAST) begin
      next_st.cnt = '0;
      next_st.stable = raw;
      next_st.press = raw;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign press = st.press;

  press_single_a: assert property (
    @(posedge ref_clk) disable iff (sys_rst) press |=> !press)
    else $error("button pulse longer than one cycle");

endmodule // panel_debounce
`default_nettype wire

// ### rtl/front_panel_console.sv
/*
  Front-panel console control: debounced panel buttons drive memory
  enter, step, display, register enter, single cycle, fill and master
  clear; lamps show the selected register while halted.
  Assumes a memory port that answers each request with one mem_done
  pulse, a register file read combinationally by code, and a bootstrap
  ROM whose word follows rom_addr in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module front_panel_console #(
  parameter int unsigned DEBOUNCE = panel_pkg::DEBOUNCE_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // panel switches
  input wire logic [15:0] switch_word,
  input wire logic [5:0] reg_select,
  input wire logic halt_run_switch,
  input wire logic panel_lock,
  input wire logic executive_option,
  // panel pushbuttons
  input wire logic btn_mem_enter,
  input wire logic btn_step,
  input wire logic btn_display,
  input wire logic btn_reg_enter,
  input wire logic btn_console_int,
  input wire logic btn_single,
  input wire logic btn_fill,
  input wire logic btn_master_clear,
  // lamps
  output logic [15:0] data_lamps,
  output logic run_lamp,
  // memory path
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [15:0] mem_wdata,
  input wire logic mem_done,
  input wire logic [15:0] mem_rdata,
  // register file
  output logic [5:0] reg_rd_code,
  input wire logic [15:0] reg_rd_data,
  output logic reg_we,
  output logic [5:0] reg_wr_code,
  output logic [15:0] reg_wr_data,
  output logic pause_load,
  output logic [1:0] pause_src,
  input wire logic [15:0] bus_word,
  // cpu control
  output logic cpu_step_req,
  input wire logic cpu_step_done,
  input wire logic [15:0] cpu_next_ip,
  output logic int_req_e,
  output logic int_inhibit,
  output logic master_clear,
  output logic [15:0] instruction_pointer,
  output logic [15:0] instruction_latch,
  // bootstrap fill
  output logic [5:0] rom_addr,
  input wire logic [15:0] rom_data,
  output logic [3:0] fill_dev,
  output logic [6:0] fill_arg,
  output logic fill_dev_ok
);

  // ----------------------------------------------------------------
  // buttons
  // ----------------------------------------------------------------
  logic [panel_pkg::BTN_N-1:0] raw;
  logic [panel_pkg::BTN_N-1:0] press;

  assign raw = {btn_master_clear, btn_fill, btn_single, btn_console_int,
                btn_reg_enter, btn_display, btn_step, btn_mem_enter};

  genvar gi;
  generate
    for (gi = 0; gi < panel_pkg::BTN_N; gi++) begin : g_btn
      panel_debounce #(.CYCLES(DEBOUNCE)) u_db (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .raw(raw[gi]),
        .press(press[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    panel_pkg::op_e op;
    logic [15:0] ip;
    logic [15:0] mrl;
    logic [15:0] il;
    logic [15:0] lamps;
    logic run;
    logic inhibit;
    logic to_il;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [15:0] mem_wdata;
    logic [5:0] rd_code;
    logic reg_we;
    logic [5:0] reg_code;
    logic [15:0] reg_data;
    logic pause_load;
    logic [1:0] pause_src;
    logic int_e;
    logic step_req;
    logic mclr;
    logic [5:0] rom_addr;
    logic [3:0] fill_dev;
    logic [6:0] fill_arg;
    logic fill_ok;
  } panel_s;

  panel_s st;
  panel_s next_st;
  logic go;

  // codes with no display source read as zero
  function automatic logic has_src(input logic [5:0] c);
    has_src = !((c >= panel_pkg::SRC_NONE_LO && c <= panel_pkg::SRC_NONE_HI)
                || c == panel_pkg::SRC_NONE_A || c == panel_pkg::SRC_NONE_B
                || c == panel_pkg::SRC_NONE_C);
  endfunction

  assign go = st.op == panel_pkg::OP_IDLE && !st.run && !panel_lock;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.mem_req = 1'b0;
    next_st.reg_we = 1'b0;
    next_st.pause_load = 1'b0;
    next_st.int_e = 1'b0;
    next_st.step_req = 1'b0;
    next_st.mclr = 1'b0;
    next_st.rd_code = reg_select;

    // lamps lag the selector by two cycles through the register file read
    if (st.run) begin
      next_st.lamps = bus_word;
    end else if (reg_select == panel_pkg::READ_LATCH_SELECT_CODE) begin
      next_st.lamps = st.mrl;
    end else if (reg_select == panel_pkg::SEL_IP) begin
      next_st.lamps = st.ip;
    end else if (has_src(reg_select)) begin
      next_st.lamps = reg_rd_data;
    end else begin
      next_st.lamps = '0;
    end

    // console interrupt stays live under lock
    if (press[panel_pkg::BTN_CONSOLE_INT] && executive_option) begin
      next_st.int_e = 1'b1;
    end

    if (!panel_lock && st.op == panel_pkg::OP_IDLE) begin
      next_st.run = halt_run_switch;
      if (halt_run_switch) begin
        next_st.inhibit = 1'b0;
      end
    end

    case (st.op)
      panel_pkg::OP_IDLE: begin
        if (!panel_lock && press[panel_pkg::BTN_MASTER_CLEAR]) begin
          next_st.ip = '0;
          next_st.il = '0;
          next_st.inhibit = 1'b0;
          next_st.int_e = 1'b0;
          next_st.mclr = 1'b1;
        end else if (go && press[panel_pkg::BTN_MEM_ENTER]) begin
          next_st.mem_req = 1'b1;
          next_st.mem_we = 1'b1;
          next_st.mem_addr = st.ip;
          next_st.mem_wdata = switch_word;
          next_st.op = panel_pkg::OP_WR_WAIT;
        end else if (go && press[panel_pkg::BTN_STEP]) begin
          next_st.ip = st.ip + 16'h0001;
          next_st.mem_req = 1'b1;
          next_st.mem_we = 1'b0;
          next_st.mem_addr = st.ip + 16'h0001;
          next_st.to_il = 1'b0;
          next_st.op = panel_pkg::OP_RD_WAIT;
        end else if (go && press[panel_pkg::BTN_DISPLAY]) begin
          if (reg_select == panel_pkg::READ_LATCH_SELECT_CODE) begin
            next_st.mem_req = 1'b1;
            next_st.mem_we = 1'b0;
            next_st.mem_addr = st.ip;
            next_st.to_il = 1'b1;
            next_st.op = panel_pkg::OP_RD_WAIT;
          end
        end else if (go && press[panel_pkg::BTN_REG_ENTER]) begin
          case (reg_select)
            panel_pkg::DEST_NONE, panel_pkg::DEST_UNA_A,
            panel_pkg::DEST_UNA_B, panel_pkg::DEST_UNA_C,
            panel_pkg::DEST_UNA_D, panel_pkg::DEST_UNA_E: begin
            end
            panel_pkg::DEST_PAUSE_A: begin
              next_st.pause_load = 1'b1;
              next_st.pause_src = panel_pkg::PSRC_A;
            end
            panel_pkg::DEST_PAUSE_B, panel_pkg::DEST_PAUSE_B2: begin
              next_st.pause_load = 1'b1;
              next_st.pause_src = panel_pkg::PSRC_B;
            end
            panel_pkg::DEST_PAUSE_BUS: begin
              next_st.pause_load = 1'b1;
              next_st.pause_src = panel_pkg::PSRC_BUS;
            end
            panel_pkg::DEST_LATCH_LO: begin
              next_st.mrl[7:0] = switch_word[7:0];
            end
            panel_pkg::DEST_LATCH_HI: begin
              next_st.mrl[15:8] = switch_word[15:8];
            end
            panel_pkg::DEST_LATCH: begin
              next_st.mrl = switch_word;
            end
            default: begin
              // pointer code also loads the cpu-side address copies
              if (reg_select == panel_pkg::DEST_IP) begin
                next_st.ip = switch_word;
              end
              next_st.reg_we = 1'b1;
              next_st.reg_code = reg_select;
              next_st.reg_data = switch_word;
            end
          endcase
        end else if (go && press[panel_pkg::BTN_SINGLE]) begin
          next_st.step_req = 1'b1;
          next_st.inhibit = 1'b1;
          next_st.op = panel_pkg::OP_CPU_WAIT;
        end else if (go && press[panel_pkg::BTN_FILL]) begin
          next_st.rom_addr = '0;
          next_st.fill_dev = switch_word[panel_pkg::FILL_DEV_LSB +: 4];
          next_st.fill_arg =
            switch_word[panel_pkg::FILL_ARG_LSB +: panel_pkg::FILL_ARG_W];
          next_st.fill_ok =
            switch_word[15:12] == panel_pkg::DEV_MOVING_DISC ||
            switch_word[15:12] == panel_pkg::DEV_FIXED_DISC ||
            switch_word[15:12] == panel_pkg::DEV_TAPE ||
            switch_word[15:12] == panel_pkg::DEV_CARD ||
            switch_word[15:12] == panel_pkg::DEV_PAPER;
          next_st.op = panel_pkg::OP_ROM;
        end
      end
      panel_pkg::OP_WR_WAIT: begin
        if (mem_done) begin
          next_st.op = panel_pkg::OP_IDLE;
        end
      end
      panel_pkg::OP_RD_WAIT: begin
        if (mem_done) begin
          next_st.mrl = mem_rdata;
          if (st.to_il) begin
            next_st.il = mem_rdata;
          end
          next_st.op = panel_pkg::OP_IDLE;
        end
      end
      panel_pkg::OP_CPU_WAIT: begin
        if (cpu_step_done) begin
          next_st.ip = cpu_next_ip;
          next_st.mem_req = 1'b1;
          next_st.mem_we = 1'b0;
          next_st.mem_addr = cpu_next_ip;
          next_st.to_il = 1'b1;
          next_st.op = panel_pkg::OP_RD_WAIT;
        end
      end
      panel_pkg::OP_ROM: begin
        next_st.mem_req = 1'b1;
        next_st.mem_we = 1'b1;
        next_st.mem_addr = {10'h000, st.rom_addr};
        next_st.mem_wdata = rom_data;
        next_st.op = panel_pkg::OP_FILL_WR;
      end
      panel_pkg::OP_FILL_WR: begin
        if (mem_done) begin
          if (st.rom_addr == panel_pkg::FILL_LAST) begin
            next_st.op = panel_pkg::OP_IDLE;
          end else begin
            next_st.rom_addr = st.rom_addr + 6'h01;
            next_st.op = panel_pkg::OP_ROM;
          end
        end
      end
      default: begin
        next_st.op = panel_pkg::OP_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign data_lamps = st.lamps;
  assign run_lamp = st.run;
  assign mem_req = st.mem_req;
  assign mem_we = st.mem_we;
  assign mem_addr = st.mem_addr;
  assign mem_wdata = st.mem_wdata;
  assign reg_rd_code = st.rd_code;
  assign reg_we = st.reg_we;
  assign reg_wr_code = st.reg_code;
  assign reg_wr_data = st.reg_data;
  assign pause_load = st.pause_load;
  assign pause_src = st.pause_src;
  assign cpu_step_req = st.step_req;
  assign int_req_e = st.int_e;
  assign int_inhibit = st.inhibit;
  assign master_clear = st.mclr;
  assign instruction_pointer = st.ip;
  assign instruction_latch = st.il;
  assign rom_addr = st.rom_addr;
  assign fill_dev = st.fill_dev;
  assign fill_arg = st.fill_arg;
  assign fill_dev_ok = st.fill_ok;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  enter_write_a: assert property (
    go && press[0] |=> mem_req && mem_we && mem_addr == $past(st.ip)
      && mem_wdata == $past(switch_word) && st.ip == $past(st.ip))
    else $error("memory enter wrong");

  step_advance_a: assert property (
    go && press[0] == 1'b0 && press[1] && !press[7]
      |=> st.ip == $past(st.ip) + 16'h0001 && mem_req && !mem_we)
    else $error("step did not advance pointer");

  console_int_a: assert property (
    press[4] && executive_option |=> int_req_e)
    else $error("console interrupt lost");

  display_latch_a: assert property (
    st.op == panel_pkg::OP_RD_WAIT && st.to_il && mem_done
      |=> st.il == $past(mem_rdata) && st.mrl == $past(mem_rdata))
    else $error("display did not load latches");

  halt_lamps_a: assert property (
    !st.run && reg_select == panel_pkg::SEL_IP |=> data_lamps == $past(st.ip))
    else $error("lamps not showing pointer");

  pause_bus_a: assert property (
    go && press[3:0] == 4'h8 && !press[7]
      && reg_select == panel_pkg::DEST_PAUSE_BUS
      |=> pause_load && pause_src == panel_pkg::PSRC_BUS && !reg_we)
    else $error("pause counter load wrong");

  single_inhibit_a: assert property (
    cpu_step_req || st.op == panel_pkg::OP_CPU_WAIT |-> int_inhibit)
    else $error("interrupts not inhibited");

  fill_range_a: assert property (
    mem_req && st.op == panel_pkg::OP_FILL_WR
      |-> mem_we && mem_addr <= {10'h000, panel_pkg::FILL_LAST})
    else $error("fill outside bootstrap range");

  lock_quiet_a: assert property (
    panel_lock && st.op == panel_pkg::OP_IDLE
      |=> !mem_req && !reg_we && !cpu_step_req && !master_clear)
    else $error("switch acted under lock");

  run_quiet_a: assert property (
    st.run && st.op == panel_pkg::OP_IDLE |=> !reg_we && !pause_load)
    else $error("register enter while running");

  fill_seen_c: cover property (st.op == panel_pkg::OP_FILL_WR && mem_done
    && st.rom_addr == panel_pkg::FILL_LAST);
  single_seen_c: cover property (cpu_step_req ##[1:50] mem_req);
  step_enter_c: cover property (
    st.op == panel_pkg::OP_RD_WAIT ##[1:200] mem_req && mem_we);

endmodule // front_panel_console
`default_nettype wire

// ### tb/cpu_side_model.sv
/*
  Far-side model of the console: word memory, register file read port,
  bootstrap ROM, CPU single step and the running bus.
  Assumes the console keeps at most one memory request outstanding.
*/
`timescale 1ns/1ps
`default_nettype none
module cpu_side_model (
  // clock and pacing
  input wire logic ref_clk,
  input wire logic slow,
  // memory path
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic mem_done,
  output logic [15:0] mem_rdata,
  // register file, rom and cpu
  input wire logic [5:0] reg_rd_code,
  output logic [15:0] reg_rd_data,
  input wire logic [5:0] rom_addr,
  output logic [15:0] rom_data,
  input wire logic cpu_step_req,
  output logic cpu_step_done,
  output logic [15:0] cpu_next_ip,
  output logic [15:0] bus_word
);
  logic [15:0] mem [0:63];
  logic pend;
  logic pend_we;
  logic [5:0] pend_a;
  logic [15:0] pend_d;
  logic [1:0] wait_n;
  int wr_cnt;
  initial begin
    for (int i = 0; i < 64; i++) mem[i] = 16'h0100 + 16'(i);
    pend = 1'b0;
    mem_done = 1'b0;
    cpu_step_done = 1'b0;
    wait_n = 2'h0;
    wr_cnt = 0;
    mem_rdata = 16'h0000;
  end
  assign reg_rd_data = {10'h2A5, reg_rd_code};
  assign rom_data = {10'h3C0, rom_addr};
  assign cpu_next_ip = 16'h0020;
  assign bus_word = 16'h5AA5;
  // read data toggles between answers so a stale sample never matches
  always @(posedge ref_clk) begin
    mem_done <= 1'b0;
    cpu_step_done <= cpu_step_req;
    mem_rdata <= ~mem_rdata;
    if (mem_req) begin
      pend <= 1'b1;
      pend_we <= mem_we;
      pend_a <= mem_addr[5:0];
      pend_d <= mem_wdata;
      wait_n <= slow ? 2'h3 : 2'h0;
    end else if (pend && wait_n != 2'h0) begin
      wait_n <= wait_n - 2'h1;
    end else if (pend) begin
      pend <= 1'b0;
      mem_done <= 1'b1;
      if (pend_we) begin
        mem[pend_a] <= pend_d;
        wr_cnt <= wr_cnt + 1;
      end else begin
        mem_rdata <= mem[pend_a];
      end
    end
  end
endmodule // cpu_side_model
`default_nettype wire

// ### tb/tb_top.sv
/*
  Self-checking bench for the front-panel console logic.
  Assumes the design is built with a debounce of 4 cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] switch_word = 16'h0000;
  logic [5:0] reg_select = 6'h00;
  logic halt_run_switch = 1'b0;
  logic panel_lock = 1'b0;
  logic executive_option = 1'b0;
  logic slow = 1'b0;
  logic [7:0] btn = 8'h00;
  logic [15:0] data_lamps, mem_addr, mem_wdata, mem_rdata, reg_rd_data;
  logic [15:0] reg_wr_data, bus_word, cpu_next_ip, instruction_pointer;
  logic [15:0] instruction_latch, rom_data;
  logic [5:0] reg_rd_code, reg_wr_code, rom_addr;
  logic [3:0] fill_dev;
  logic [6:0] fill_arg;
  logic [1:0] pause_src, last_psrc;
  logic run_lamp, mem_req, mem_we, mem_done, reg_we, pause_load;
  logic cpu_step_req, cpu_step_done, int_req_e, int_inhibit;
  logic master_clear, fill_dev_ok;
  logic [15:0] last_rdata;
  logic [5:0] last_rcode;
  int mcnt = 0;
  int num_errors = 0;
  int checked = 0;
  int pcnt = 0;
  int icnt = 0;
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (pause_load) last_psrc <= pause_src;
    if (pause_load) pcnt <= pcnt + 1;
    if (int_req_e) icnt <= icnt + 1;
    if (master_clear) mcnt <= mcnt + 1;
    if (reg_we) last_rcode <= reg_wr_code;
    if (reg_we) last_rdata <= reg_wr_data;
  end
  front_panel_console #(.DEBOUNCE(4)) dut_u (
    .ref_clk, .sys_rst, .switch_word, .reg_select, .halt_run_switch,
    .panel_lock, .executive_option,
    .btn_mem_enter(btn[0]), .btn_step(btn[1]), .btn_display(btn[2]),
    .btn_reg_enter(btn[3]), .btn_console_int(btn[4]),
    .btn_single(btn[5]), .btn_fill(btn[6]), .btn_master_clear(btn[7]),
    .data_lamps, .run_lamp, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_done, .mem_rdata, .reg_rd_code, .reg_rd_data, .reg_we,
    .reg_wr_code, .reg_wr_data, .pause_load, .pause_src, .bus_word,
    .cpu_step_req, .cpu_step_done, .cpu_next_ip, .int_req_e,
    .int_inhibit, .master_clear, .instruction_pointer,
    .instruction_latch, .rom_addr, .rom_data, .fill_dev, .fill_arg,
    .fill_dev_ok);
  cpu_side_model model_u (
    .ref_clk, .slow, .mem_req, .mem_we, .mem_addr, .mem_wdata,
    .mem_done, .mem_rdata, .reg_rd_code, .reg_rd_data, .rom_addr,
    .rom_data, .cpu_step_req, .cpu_step_done, .cpu_next_ip, .bus_word);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // held past the debounce, then long enough for a slow answer
  task automatic press(input int b);
    @(negedge ref_clk);
    btn[b] = 1'b1;
    repeat (8) @(negedge ref_clk);
    btn[b] = 1'b0;
    repeat (14) @(negedge ref_clk);
  endtask
  task automatic setreg(input logic [5:0] sel, input logic [15:0] v);
    reg_select = sel;
    switch_word = v;
    press(3);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_enter;
    chk(instruction_pointer, 16'h0000);
    setreg(6'h3C, 16'h0010);
    chk(instruction_pointer, 16'h0010);
    chk(data_lamps, 16'h0010);
    chk({10'h0, last_rcode}, 16'h003C);
    chk(last_rdata, 16'h0010);
    switch_word = 16'hABCD;
    press(0);
    chk(model_u.mem[16], 16'hABCD);
    chk(instruction_pointer, 16'h0010);
  endtask
  task automatic t_step;
    reg_select = 6'h3F;
    press(1);
    chk(instruction_pointer, 16'h0011);
    chk(data_lamps, 16'h0111);
    switch_word = 16'h1234;
    press(0);
    chk(model_u.mem[17], 16'h1234);
  endtask
  task automatic t_display;
    setreg(6'h3C, 16'h0010);
    reg_select = 6'h3F;
    press(2);
    chk(instruction_latch, 16'hABCD);
    chk(data_lamps, 16'hABCD);
    chk(instruction_pointer, 16'h0010);
  endtask
  task automatic t_pause;
    logic [1:0] exp [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
    for (int i = 0; i < 4; i++) begin
      setreg(6'h14 + 6'(i), 16'h0007);
      chk({14'h0, last_psrc}, {14'h0, exp[i]});
    end
    setreg(6'h12, 16'h0007);
    chk(16'(pcnt), 16'h0004);
    chk(data_lamps, 16'h0000);
    reg_select = 6'h05;
    repeat (3) @(negedge ref_clk);
    chk(data_lamps, 16'hA945);
    setreg(6'h3F, 16'h1122);
    setreg(6'h3D, 16'h5566);
    setreg(6'h3E, 16'h3344);
    reg_select = 6'h3F;
    repeat (2) @(negedge ref_clk);
    chk(data_lamps, 16'h3366);
  endtask
  task automatic t_lock_int;
    panel_lock = 1'b1;
    switch_word = 16'hEEEE;
    press(0);
    chk(model_u.mem[16], 16'hABCD);
    executive_option = 1'b1;
    press(4);
    chk(16'(icnt), 16'h0001);
    panel_lock = 1'b0;
    executive_option = 1'b0;
    press(4);
    chk(16'(icnt), 16'h0001);
  endtask
  task automatic t_single;
    slow = 1'b1;
    reg_select = 6'h3F;
    press(5);
    chk(instruction_pointer, 16'h0020);
    chk(data_lamps, 16'h0120);
    chk({15'h0, int_inhibit}, 16'h0001);
    slow = 1'b0;
  endtask
  task automatic t_run;
    halt_run_switch = 1'b1;
    switch_word = 16'h7777;
    press(0);
    chk(data_lamps, 16'h5AA5);
    chk(model_u.mem[16], 16'hABCD);
    chk({15'h0, run_lamp}, 16'h0001);
    chk({15'h0, int_inhibit}, 16'h0000);
    halt_run_switch = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk({15'h0, run_lamp}, 16'h0000);
  endtask
  task automatic t_fill(input logic [15:0] sw, input logic [3:0] dev,
                        input logic ok);
    int w0;
    int m0;
    w0 = model_u.wr_cnt;
    m0 = mcnt;
    switch_word = sw;
    press(7);
    chk(instruction_latch, 16'h0000);
    chk(16'(mcnt - m0), 16'h0001);
    press(6);
    for (int n = 0; model_u.wr_cnt - w0 != 46; n++) begin
      if (n > 2000) begin
        num_errors++;
        break;
      end
      @(negedge ref_clk);
    end
    chk({12'h0, fill_dev}, {12'h0, dev});
    chk({15'h0, fill_dev_ok}, {15'h0, ok});
    chk({9'h0, fill_arg}, {9'h0, sw[7:1]});
    chk(model_u.mem[45], 16'hF02D);
    chk(instruction_pointer, 16'h0000);
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    sys_rst = 1'b0;
    t_enter();
    t_step();
    t_display();
    t_pause();
    t_lock_int();
    t_single();
    t_run();
    t_fill(16'h400A, 4'h4, 1'b1);
    t_fill(16'h1006, 4'h1, 1'b1);
    t_fill(16'h3000, 4'h3, 1'b0);
    final_report();
  end
endmodule // tb_top
`default_nettype wire
